/* File: logic/sbcr_consts.svh */
// Constants of the serial boot command responder: codes, reply positions, tables.
// Assumes inclusion by the responder module only; definitions only.
`ifndef SBCR_CONSTS_SVH
`define SBCR_CONSTS_SVH

// Operation command codes
`define SBCR_CMD_RAM 8'h10
`define SBCR_CMD_SUM 8'h20
`define SBCR_CMD_INFO 8'h30
`define SBCR_CMD_ERASE 8'h40

// Acknowledge codes
`define SBCR_ACK_UART 8'h86
`define SBCR_NIB_RXERR 4'h8
`define SBCR_NIB_CMDERR 4'h1
`define SBCR_ACK_CK_RXERR 8'h18
`define SBCR_ACK_CK_BAD 8'h11
`define SBCR_ACK_CK_OK 8'h10
`define SBCR_ERASE_OK 8'h4f
`define SBCR_ERASE_FAIL 8'h4c
`define SBCR_ERASE_ACK_OK 8'hb1
`define SBCR_ERASE_ACK_FAIL 8'hb4

// Product information reply byte positions
`define SBCR_POS_FIRST 7'd5
`define SBCR_POS_NAME 7'd9
`define SBCR_POS_ADDR 7'd21
`define SBCR_POS_DUMMY 7'd37
`define SBCR_POS_GEOM 7'd47
`define SBCR_POS_CKSUM 7'd84

// Password exchange positions
`define SBCR_POS_PW_LAST 7'd16
`define SBCR_POS_PW_CKSUM 7'd17

// Bytes 21..36, byte 21 in the low bits
`define SBCR_TBL_ADDR 128'h000083ff00006bff000004000008fef4
// Bytes 47..83, byte 47 in the low bits
`define SBCR_TBL_GEOM {72'h02000010000008c000, 72'h020000700000070000, \
  72'h060000800000010000, 16'h000a, 32'h0008ffff, 32'h00010000}

`endif

/* File: logic/sbcr_pkg.sv */
// Types of the serial boot command responder.
// Assumes nothing of its surroundings.
package sbcr_pkg;

  typedef enum logic [2:0] {
    SBCR_ST_DETECT = 3'b000,
    SBCR_ST_ACK86 = 3'b001,
    SBCR_ST_CMD = 3'b011,
    SBCR_ST_INFO = 3'b010,
    SBCR_ST_PWD = 3'b110,
    SBCR_ST_ERASE = 3'b111,
    SBCR_ST_ERST = 3'b101,
    SBCR_ST_ERACK = 3'b100
  } sbcr_state_t;

  typedef struct packed {
    sbcr_state_t state;
    logic [2:0] sync;
    logic lvl;
    logic [15:0] timer;
    logic [1:0] edge_cnt;
    logic [15:0] t_a;
    logic [15:0] t_b;
    logic [15:0] t_c;
    logic [6:0] idx;
    logic [7:0] sum;
    logic pw_bad;
    logic rx_bad;
    logic er_ok;
    logic [7:0] last_cmd;
    logic tx_valid;
    logic [7:0] tx_data;
    logic erase_req;
    logic ram_go;
    logic sum_go;
    logic uart_mode;
    logic [12:0] bit_period;
  } sbcr_regs_t;

endpackage

/* File: logic/sbcr_responder.sv */
// Serial boot command responder: baud detection, command decode, acknowledges,
// product information reply, password check and erase sequencing.
// Assumes an external UART receiver/transmitter on clk that moves whole bytes,
// and a flash controller that performs the whole-chip erase.
`timescale 1ns/1ps
`include "sbcr_consts.svh"

module sbcr_responder import sbcr_pkg::*; #(
  parameter logic [15:0] SPAN_MIN = 16'h0050,
  parameter logic [15:0] SPAN_MAX = 16'hfff0,
  // Arbitrary product name, first byte in the low bits
  parameter logic [95:0] PRODUCT_NAME = 96'h3030_4543_4956_4544_544f_4f42
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Receive pin, timed during detection
  input wire logic rxd,
  // Received bytes from the UART
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_err,
  // Bytes to the UART transmitter
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // Detected link setup
  output logic uart_mode,
  output logic [12:0] bit_period,
  // Flash contents used by the protocol
  input wire logic [31:0] flash_id,
  input wire logic [95:0] flash_password,
  // Erase handshake
  output logic erase_req,
  input wire logic erase_done,
  input wire logic erase_ok,
  // Hand-off to command bodies handled elsewhere
  output logic ram_go,
  output logic sum_go
);

  sbcr_regs_t r_reg;
  sbcr_regs_t r_next;

  logic edge_seen;
  logic tx_free;
  logic [15:0] low_first;
  logic [15:0] low_second;
  logic [15:0] span;
  logic [7:0] pw_byte;
  logic [7:0] info_b;

  ////////////////////////////////////////////////////////////////////////////
  // Product information reply content
  function automatic logic [7:0] info_byte(input logic [6:0] i, input logic [31:0] id,
                                           input logic [7:0] s);
    logic [6:0] k;
    logic [7:0] b;
    k = 7'd0;
    b = 8'h00;
    if (i < `SBCR_POS_NAME) begin
      k = i - `SBCR_POS_FIRST;
      b = 8'(id >> {k[1:0], 3'b000});
    end else if (i < `SBCR_POS_ADDR) begin
      k = i - `SBCR_POS_NAME;
      b = 8'(PRODUCT_NAME >> {k[3:0], 3'b000});
    end else if (i < `SBCR_POS_DUMMY) begin
      k = i - `SBCR_POS_ADDR;
      b = 8'(`SBCR_TBL_ADDR >> {k[3:0], 3'b000});
    end else if (i < `SBCR_POS_GEOM) begin
      b = 8'h00;
    end else if (i < `SBCR_POS_CKSUM) begin
      k = i - `SBCR_POS_GEOM;
      b = 8'(`SBCR_TBL_GEOM >> {k[5:0], 3'b000});
    end else begin
      b = 8'h00 - s;
    end
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    r_next = r_reg;
    r_next.ram_go = 1'b0;
    r_next.sum_go = 1'b0;
    r_next.sync = {r_reg.sync[1:0], rxd};
    r_next.timer = r_reg.timer + 16'h0001;
    edge_seen = (r_reg.sync[1] == r_reg.sync[2]) && (r_reg.sync[2] != r_reg.lvl);
    if (edge_seen) begin
      r_next.lvl = r_reg.sync[2];
    end
    if (r_reg.tx_valid && tx_ready) begin
      r_next.tx_valid = 1'b0;
    end
    tx_free = !r_reg.tx_valid;
    low_first = r_reg.t_b - r_reg.t_a;
    low_second = r_reg.timer - r_reg.t_c;
    span = r_reg.timer - r_reg.t_a;
    pw_byte = 8'(flash_password >> {r_reg.idx[3:0] - 4'd5, 3'b000});
    info_b = info_byte(r_reg.idx, flash_id, r_reg.sum);
    unique case (r_reg.state)
      SBCR_ST_DETECT: begin
        if (edge_seen) begin
          unique case (r_reg.edge_cnt)
            2'd0: begin
              if (!r_reg.sync[2]) begin
                r_next.t_a = r_reg.timer;
                r_next.edge_cnt = 2'd1;
              end
            end
            2'd1: begin
              r_next.t_b = r_reg.timer;
              r_next.edge_cnt = 2'd2;
            end
            2'd2: begin
              r_next.t_c = r_reg.timer;
              r_next.edge_cnt = 2'd3;
            end
            2'd3: begin
              r_next.edge_cnt = 2'd0;
              if (low_first < low_second && span >= SPAN_MIN && span <= SPAN_MAX) begin
                r_next.uart_mode = 1'b1;
                r_next.bit_period = span[15:3];
                r_next.state = SBCR_ST_ACK86;
              end
            end
          endcase
        end
      end
      SBCR_ST_ACK86: begin
        if (tx_free) begin
          r_next.tx_valid = 1'b1;
          r_next.tx_data = `SBCR_ACK_UART;
          r_next.state = SBCR_ST_CMD;
        end
      end
      SBCR_ST_CMD: begin
        if (rx_valid) begin
          r_next.tx_valid = 1'b1;
          r_next.idx = `SBCR_POS_FIRST;
          r_next.sum = 8'h00;
          r_next.pw_bad = 1'b0;
          r_next.rx_bad = 1'b0;
          if (rx_err) begin
            r_next.tx_data = {r_reg.last_cmd[7:4], `SBCR_NIB_RXERR};
          end else begin
            r_next.last_cmd = rx_data;
            r_next.tx_data = rx_data;
            unique case (rx_data)
              `SBCR_CMD_RAM: r_next.state = SBCR_ST_PWD;
              `SBCR_CMD_SUM: r_next.sum_go = 1'b1;
              `SBCR_CMD_INFO: r_next.state = SBCR_ST_INFO;
              `SBCR_CMD_ERASE: begin
                r_next.erase_req = 1'b1;
                r_next.state = SBCR_ST_ERASE;
              end
              default: r_next.tx_data = {rx_data[7:4], `SBCR_NIB_CMDERR};
            endcase
          end
        end
      end
      SBCR_ST_INFO: begin
        if (tx_free) begin
          r_next.tx_valid = 1'b1;
          r_next.tx_data = info_b;
          r_next.sum = r_reg.sum + info_b;
          r_next.idx = r_reg.idx + 7'd1;
          if (r_reg.idx == `SBCR_POS_CKSUM) begin
            r_next.state = SBCR_ST_CMD;
          end
        end
      end
      SBCR_ST_PWD: begin
        if (rx_valid) begin
          r_next.rx_bad = r_reg.rx_bad | rx_err;
          r_next.sum = r_reg.sum + rx_data;
          r_next.idx = r_reg.idx + 7'd1;
          if (r_reg.idx <= `SBCR_POS_PW_LAST && rx_data != pw_byte) begin
            r_next.pw_bad = 1'b1;
          end
          if (r_reg.idx == `SBCR_POS_PW_CKSUM) begin
            r_next.tx_valid = 1'b1;
            r_next.state = SBCR_ST_CMD;
            if (r_reg.rx_bad || rx_err) begin
              r_next.tx_data = `SBCR_ACK_CK_RXERR;
            end else if (r_reg.pw_bad || (r_reg.sum + rx_data) != 8'h00) begin
              r_next.tx_data = `SBCR_ACK_CK_BAD;
            end else begin
              r_next.tx_data = `SBCR_ACK_CK_OK;
              r_next.ram_go = 1'b1;
            end
          end
        end
      end
      SBCR_ST_ERASE: begin
        if (erase_done) begin
          r_next.erase_req = 1'b0;
          r_next.er_ok = erase_ok;
          r_next.state = SBCR_ST_ERST;
        end
      end
      SBCR_ST_ERST: begin
        if (tx_free) begin
          r_next.tx_valid = 1'b1;
          r_next.tx_data = r_reg.er_ok ? `SBCR_ERASE_OK : `SBCR_ERASE_FAIL;
          r_next.state = SBCR_ST_ERACK;
        end
      end
      SBCR_ST_ERACK: begin
        if (tx_free) begin
          r_next.tx_valid = 1'b1;
          r_next.tx_data = r_reg.er_ok ? `SBCR_ERASE_ACK_OK : `SBCR_ERASE_ACK_FAIL;
          r_next.state = SBCR_ST_CMD;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r_reg <= '{state: SBCR_ST_DETECT, sync: 3'b111, lvl: 1'b1, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign tx_valid = r_reg.tx_valid;
  assign tx_data = r_reg.tx_data;
  assign uart_mode = r_reg.uart_mode;
  assign bit_period = r_reg.bit_period;
  assign erase_req = r_reg.erase_req;
  assign ram_go = r_reg.ram_go;
  assign sum_go = r_reg.sum_go;

endmodule

/* File: tb/sbcr_assertions.sv */
// Port checker for the serial boot command responder.
// Assumes it is bound to sbcr_responder; one clock domain.
`timescale 1ns/1ps
module sbcr_assertions (
  // Watched ports
  input wire logic clk,
  input wire logic rst_b,
  input wire logic rx_valid,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic uart_mode,
  input wire logic erase_req,
  input wire logic erase_done,
  input wire logic erase_ok,
  input wire logic ram_go,
  input wire logic sum_go
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  a_tx_held: assert property (
    tx_valid && !tx_ready && !rx_valid |=> tx_valid && $stable(tx_data)) else $error("tx lost");
  a_link_kept: assert property (
    uart_mode |=> uart_mode) else $error("uart mode dropped");
  a_first_ack: assert property (
    $rose(uart_mode) |=> tx_valid && tx_data == 8'h86) else $error("no 86 ack");
  a_quiet_detect: assert property (
    !uart_mode |-> !tx_valid) else $error("sent during detection");
  a_sum_echo: assert property (
    sum_go |-> tx_valid && tx_data == 8'h20) else $error("sum not echoed");
  a_pass_ack: assert property (
    ram_go |-> tx_valid && tx_data == 8'h10) else $error("ram go without 10");
  a_erase_echo: assert property (
    $rose(erase_req) |-> tx_valid && tx_data == 8'h40) else $error("erase not echoed");
  a_erase_wait: assert property (
    erase_req && !erase_done |=> erase_req) else $error("erase dropped early");
  a_erase_good: assert property (
    erase_req && erase_done && erase_ok |-> ##[1:4] tx_valid && tx_data == 8'h4f)
    else $error("no 4f");
  a_erase_bad: assert property (
    erase_req && erase_done && !erase_ok |-> ##[1:4] tx_valid && tx_data == 8'h4c)
    else $error("no 4c");
endmodule

bind sbcr_responder sbcr_assertions chk (.clk, .rst_b, .rx_valid, .tx_valid, .tx_data,
  .tx_ready, .uart_mode, .erase_req, .erase_done, .erase_ok, .ram_go, .sum_go);

/* File: tb/sbcr_host.sv */
// Model of the programming controller on the serial side.
// Assumes the bench asks it for frames and reads the bytes it took.
`timescale 1ns/1ps
module sbcr_host #(
  parameter int BIT = 16
) (
  input wire logic clk,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic rxd
);
  logic [7:0] got[$];
  initial begin
    rxd = 1'h1;
    tx_ready = 1'h0;
  end
  // Stalls every other cycle when slow
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
    end
    tx_ready <= slow ? !tx_ready : 1'h1;
  end
  ////////////////////////////////////////
  // Start bit, data LSB first, stop bit; line idles high
  task automatic send_frame(input logic [7:0] b);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      rxd <= f[i];
      repeat (BIT - 1) @(posedge clk);
    end
  endtask
endmodule

/* File: tb/test_sbcr_responder.sv */
// Self-checking bench of the serial boot command responder.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps
module test_sbcr_responder;
  logic clk, rxd, tx_valid, tx_ready, uart_mode, erase_req, ram_go, sum_go;
  logic rst_b = 1'h0, rx_valid = 1'h0, rx_err = 1'h0, slow = 1'h0;
  logic erase_done = 1'h0, erase_ok = 1'h0;
  logic [7:0] rx_data = 8'h00;
  logic [7:0] tx_data;
  logic [12:0] bit_period;
  logic [31:0] fid = 32'h5a3c0f11;
  logic [95:0] fpw = 96'h0123456789abcdef13579bdf;
  logic [111:0] geo = {32'h00010000, 16'h000a, 32'h0008ffff, 32'h00010000};
  int fail_count = 0;
  int checks_done = 0;
  sbcr_responder dut (.clk, .rst_b, .rxd, .rx_valid, .rx_data, .rx_err, .tx_valid,
    .tx_data, .tx_ready, .uart_mode, .bit_period, .flash_id(fid), .flash_password(fpw),
    .erase_req, .erase_done, .erase_ok, .ram_go, .sum_go);
  sbcr_host #(.BIT(16)) host (.clk, .slow, .tx_valid, .tx_data, .tx_ready, .rxd);
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic send(input logic [7:0] b, input logic e);
    @(posedge clk);
    rx_valid <= 1'h1;
    rx_data <= b;
    rx_err <= e;
    @(posedge clk);
    rx_valid <= 1'h0;
  endtask
  task automatic take(output logic [7:0] b);
    b = 8'h00;
    for (int k = 0; k < 4000 && host.got.size() == 0; k++) begin
      @(posedge clk);
      #1;
    end
    if (host.got.size() == 0) begin
      fail_count++;
      $display("BAD %0t no byte sent", $time);
    end else begin
      b = host.got.pop_front();
    end
  endtask
  task automatic expect_tx(input logic [7:0] exp);
    logic [7:0] b;
    take(b);
    check(b, exp);
  endtask
  ////////////////////////////////////////
  task automatic t_detect;
    host.send_frame(8'h86);
    expect_tx(8'h86);
    check(bit_period, 16'h0010);
    check(uart_mode, 16'h0001);
    send(8'h55, 1'h0);
    expect_tx(8'h51);
    send(8'h30, 1'h1);
    expect_tx(8'h58);
    send(8'h20, 1'h0);
    expect_tx(8'h20);
    $display("detect and commands done");
  endtask
  task automatic t_info;
    logic [7:0] b;
    logic [7:0] s;
    s = 8'h00;
    slow <= 1'h1;
    send(8'h30, 1'h0);
    expect_tx(8'h30);
    for (int i = 5; i < 84; i++) begin
      take(b);
      s = s + b;
      if (i < 9) begin
        check(b, fid[8*(i-5)+:8]);
      end
      if (i > 36 && i < 47) begin
        check(b, 8'h00);
      end
      if (i > 46 && i < 61) begin
        check(b, geo[8*(i-47)+:8]);
      end
    end
    s = -s;
    take(b);
    check(b, s);
    slow <= 1'h0;
    send(8'h20, 1'h0);
    expect_tx(8'h20);
    $display("info done");
  endtask
  task automatic t_pass(input int m);
    logic [7:0] b;
    logic [7:0] s;
    s = 8'h00;
    send(8'h10, 1'h0);
    expect_tx(8'h10);
    for (int i = 0; i < 12; i++) begin
      b = fpw[8*i+:8];
      if (m == 1 && i == 11) begin
        b = ~b;
      end
      s = s + b;
      send(b, m == 2 && i == 3);
    end
    s = -s;
    send(s, 1'h0);
    expect_tx(m == 0 ? 8'h10 : m == 1 ? 8'h11 : 8'h18);
    $display("password case %0d done", m);
  endtask
  task automatic t_erase(input logic ok);
    send(8'h40, 1'h0);
    expect_tx(8'h40);
    repeat (5) @(posedge clk);
    check(erase_req, 16'h0001);
    erase_ok <= ok;
    erase_done <= 1'h1;
    @(posedge clk);
    erase_done <= 1'h0;
    expect_tx(ok ? 8'h4f : 8'h4c);
    expect_tx(ok ? 8'hb1 : 8'hb4);
    $display("erase case %0d done", ok);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'h1;
    repeat (8) @(posedge clk);
    t_detect;
    t_info;
    for (int m = 0; m < 3; m++) begin
      t_pass(m);
    end
    t_erase(1'h1);
    t_erase(1'h0);
    end_of_test;
  end
  initial begin
    #200000;
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test;
  end
endmodule
